// [ext_access_pkg.sv]
// Constants, field layouts and carrier types for the external access register set
// Contract
// - Three-bit external address selects one of eight host-visible registers.
// - Serial control port reaches the same register map with the same effects.
// - Auto-increment bit set steps the channel address after each channel access.
// - Broadcast clear: instruction bits must equal chip identity pins to accept.
// - Broadcast set: instruction bits are a broadcast code; identity pins used only by chip-subset codes.
// - Broadcast code 0000 selects all chips and all channels.
// - Broadcast code 0001 selects channels 0, 1 and 2 of every chip.
// - Broadcast code 0010 selects channels 1, 2 and 3 of every chip.
// - Broadcast code 0100 selects every chip, channel from upper address bits.
// - Codes 1000/1001 select chips whose identity bit 0 matches code bit 0.
// - Codes 11xx select chips whose two low identity bits match the code.
// - Chip-subset codes pick one channel from upper internal address bits.
// - Readback is invalid while broadcast is set; host clears broadcast first.
// - Control bits 1-0 give address bits 9:8, ignored for multi-channel codes.
// - Soft-sync register is write-only with test, hop, start and sync fields.
// - Pin-sync register is write-only with toggle, first-only, enables fields.
// - Write-only sleep register holds one sleep bit per channel.
// - High data register keeps four bits, reads back only those four.
// - Writing the low data register triggers the internal write.
// - Reading the low data register launches the internal read.
package ext_access_pkg;

    // External register addresses
    localparam logic [2:0] ADDR_DATA_LOW = 3'h0;
    localparam logic [2:0] ADDR_DATA_MID = 3'h1;
    localparam logic [2:0] ADDR_DATA_HIGH = 3'h2;
    localparam logic [2:0] ADDR_POWER_DOWN = 3'h3;
    localparam logic [2:0] ADDR_PIN_SYNC = 3'h4;
    localparam logic [2:0] ADDR_SOFT_SYNC = 3'h5;
    localparam logic [2:0] ADDR_CHAN_PTR = 3'h6;
    localparam logic [2:0] ADDR_ACCESS_CTRL = 3'h7;

    // Access control, power-down and high data field positions
    localparam int ACR_AUTO_INC = 7;
    localparam int ACR_BROADCAST = 6;
    localparam int ACR_INSTR_HI = 5;
    localparam int ACR_INSTR_LO = 2;
    localparam int ACR_UPPER_HI = 1;
    localparam int ACR_UPPER_LO = 0;
    localparam int SLEEP_IO_SEL = 5;
    localparam int SLEEP_CHAN_HI = 3;
    localparam int HIGH_NIBBLE_HI = 3;

    // Reset values and the read value of unmapped registers
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Broadcast instruction codes and channel masks
    localparam logic [3:0] BC_ALL = 4'h0;
    localparam logic [3:0] BC_CH012 = 4'h1;
    localparam logic [3:0] BC_CH123 = 4'h2;
    localparam logic [3:0] BC_ALL_CHIPS = 4'h4;
    localparam logic [2:0] BC_BIT0_PREFIX = 3'h4;
    localparam logic [1:0] BC_BIT01_PREFIX = 2'h3;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam logic [3:0] MASK_CH012 = 4'h7;
    localparam logic [3:0] MASK_CH123 = 4'he;
    localparam logic [3:0] MASK_NONE = 4'h0;

    // Serial frame layout: command byte then data byte, msb first
    localparam int SER_CMD_READ = 7;
    localparam logic [4:0] SER_CMD_BITS = 5'h08;
    localparam logic [4:0] SER_FRAME_BITS = 5'h10;

    typedef struct packed {
        logic pseudo_random_test_enable;
        logic test_source_select;
        logic hop;
        logic start;
        logic [3:0] sync;
    } soft_sync_t;

    typedef struct packed {
        logic input_enable_toggle;
        logic first_sync_only;
        logic hop_en;
        logic start_en;
        logic [3:0] sync_en;
    } pin_sync_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic io_sel;
        logic [3:0] chan_mask;
        logic [9:0] addr;
        logic [19:0] wdata;
    } int_req_t;

endpackage

// [channel_select_decode.sv]
// Chip and channel selection decode from access control fields
`default_nettype none
module channel_select_decode (
    input wire logic broadcast,
    input wire logic [3:0] instr,
    input wire logic [3:0] chip_id,
    input wire logic [1:0] upper_addr,
    output logic [3:0] chan_mask
);
    logic [3:0] one_chan;

    // Single channel picked by upper address bits
    always_comb begin
        one_chan = ext_access_pkg::MASK_NONE;
        one_chan[upper_addr] = 1'b1;
    end

    // Mask of channels of this chip that take the access
    always_comb begin
        chan_mask = ext_access_pkg::MASK_NONE;
        if (!broadcast) begin
            if (instr == chip_id) begin
                chan_mask = one_chan;
            end
        end else if (instr == ext_access_pkg::BC_ALL) begin
            chan_mask = ext_access_pkg::MASK_ALL;
        end else if (instr == ext_access_pkg::BC_CH012) begin
            chan_mask = ext_access_pkg::MASK_CH012;
        end else if (instr == ext_access_pkg::BC_CH123) begin
            chan_mask = ext_access_pkg::MASK_CH123;
        end else if (instr == ext_access_pkg::BC_ALL_CHIPS) begin
            chan_mask = one_chan;
        end else if (instr[3:1] == ext_access_pkg::BC_BIT0_PREFIX) begin
            if (chip_id[0] == instr[0]) begin
                chan_mask = one_chan;
            end
        end else if (instr[3:2] == ext_access_pkg::BC_BIT01_PREFIX) begin
            // identity low pair; channel from address
            if (chip_id[1:0] == instr[1:0]) begin
                chan_mask = one_chan;
            end
        end
    end
endmodule
`default_nettype wire

// [ext_access_regs.sv]
// External access register set with parallel and serial host ports
`default_nettype none
module ext_access_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] chip_identity_pins,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [2:0] up_addr,
    input wire logic [7:0] up_wdata,
    output logic [7:0] up_rdata,
    output logic up_rvalid,
    output logic up_ready,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sfs_n,
    output logic sdo,
    output ext_access_pkg::int_req_t int_req,
    input wire logic [19:0] int_rdata,
    output ext_access_pkg::soft_sync_t soft_sync,
    output logic soft_sync_stb,
    output ext_access_pkg::pin_sync_t pin_sync,
    output logic [3:0] sleep
);
    typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_CAP} rd_state_t;

    rd_state_t state_ff;
    logic [7:0] access_target_control_ff;
    logic [7:0] channel_address_pointer_ff;
    logic [7:0] data_low_ff;
    logic [7:0] data_mid_ff;
    logic [3:0] data_high_ff;
    logic [7:0] power_down_ff;
    ext_access_pkg::soft_sync_t soft_sync_ff;
    logic soft_sync_stb_ff;
    ext_access_pkg::pin_sync_t pin_sync_ff;
    ext_access_pkg::int_req_t int_req_ff;
    logic [7:0] up_rdata_ff;
    logic up_rvalid_ff;
    logic up_ready_ff;
    logic ans_ser_ff;
    logic sclk_ff;
    logic [4:0] ser_cnt_ff;
    logic [15:0] ser_in_ff;
    logic [7:0] ser_out_ff;
    logic ser_pend_ff;
    logic ser_pend_rd_ff;
    logic [2:0] ser_pend_addr_ff;
    logic [7:0] ser_pend_data_ff;

    logic [3:0] chan_mask;
    logic acc_go;
    logic acc_rd;
    logic acc_ser;
    logic [2:0] acc_addr;
    logic [7:0] acc_wdata;
    logic chan_hit;
    logic dr0_wr;
    logic dr0_rd;
    logic ans_go;
    logic [7:0] ans_data;
    logic ser_take;
    logic sclk_rise;
    logic [15:0] nxt_ser_in;
    logic [4:0] nxt_ser_cnt;
    logic [7:0] nxt_pointer;
    logic bcast;

    channel_select_decode u_decode (
        .broadcast(access_target_control_ff[ext_access_pkg::ACR_BROADCAST]),
        .instr(access_target_control_ff[ext_access_pkg::ACR_INSTR_HI:
                                        ext_access_pkg::ACR_INSTR_LO]),
        .chip_id(chip_identity_pins),
        .upper_addr(access_target_control_ff[ext_access_pkg::ACR_UPPER_HI:
                                             ext_access_pkg::ACR_UPPER_LO]),
        .chan_mask(chan_mask)
    );

    // one access path for both ports; parallel first, serial waits
    always_comb begin
        acc_go = 1'b0;
        acc_rd = 1'b0;
        acc_ser = 1'b0;
        acc_addr = up_addr;
        acc_wdata = up_wdata;
        if (state_ff == ST_IDLE) begin
            if (up_wr || up_rd) begin
                acc_go = 1'b1;
                acc_rd = up_rd && !up_wr;
            end else if (ser_pend_ff) begin
                acc_go = 1'b1;
                acc_rd = ser_pend_rd_ff;
                acc_ser = 1'b1;
                acc_addr = ser_pend_addr_ff;
                acc_wdata = ser_pend_data_ff;
            end
        end
    end

    // channel-space access only when some channel is selected
    assign chan_hit = chan_mask != ext_access_pkg::MASK_NONE;
    assign dr0_wr = acc_go && !acc_rd && (acc_addr == ext_access_pkg::ADDR_DATA_LOW)
                    && chan_hit;
    assign dr0_rd = acc_go && acc_rd && (acc_addr == ext_access_pkg::ADDR_DATA_LOW)
                    && chan_hit;
    assign bcast = access_target_control_ff[ext_access_pkg::ACR_BROADCAST];
    assign ser_take = acc_go && acc_ser;
    assign nxt_pointer = channel_address_pointer_ff + 8'h01;

    // Read answer source and data for the register map
    always_comb begin
        ans_go = 1'b0;
        ans_data = ext_access_pkg::UNMAPPED_READ;
        if (state_ff == ST_RD_CAP) begin
            ans_go = 1'b1;
            ans_data = int_rdata[7:0];
        end else if (acc_go && acc_rd && !dr0_rd) begin
            ans_go = 1'b1;
            unique case (acc_addr)
                ext_access_pkg::ADDR_ACCESS_CTRL: ans_data = access_target_control_ff;
                ext_access_pkg::ADDR_CHAN_PTR: ans_data = bcast ?
                    ext_access_pkg::UNMAPPED_READ : channel_address_pointer_ff;
                ext_access_pkg::ADDR_DATA_MID: ans_data = data_mid_ff;
                ext_access_pkg::ADDR_DATA_HIGH: ans_data = {4'h0, data_high_ff};
                ext_access_pkg::ADDR_DATA_LOW: ans_data = ext_access_pkg::UNMAPPED_READ;
                ext_access_pkg::ADDR_POWER_DOWN,
                ext_access_pkg::ADDR_PIN_SYNC,
                ext_access_pkg::ADDR_SOFT_SYNC: ans_data = ext_access_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // Internal read sequencing for low data register reads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: if (dr0_rd) state_ff <= ST_RD_WAIT;
                ST_RD_WAIT: state_ff <= ST_RD_CAP;
                ST_RD_CAP: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Access control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            access_target_control_ff <= ext_access_pkg::BYTE_RESET;
        end else if (acc_go && !acc_rd && acc_addr == ext_access_pkg::ADDR_ACCESS_CTRL) begin
            access_target_control_ff <= acc_wdata;
        end
    end

    // Channel address pointer with auto-increment
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_address_pointer_ff <= ext_access_pkg::BYTE_RESET;
        end else if (acc_go && !acc_rd && acc_addr == ext_access_pkg::ADDR_CHAN_PTR) begin
            channel_address_pointer_ff <= acc_wdata;
        end else if ((dr0_wr || state_ff == ST_RD_CAP)
                     && access_target_control_ff[ext_access_pkg::ACR_AUTO_INC]) begin
            channel_address_pointer_ff <= nxt_pointer;
        end
    end

    // Data registers, loaded by host writes and by internal reads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_low_ff <= ext_access_pkg::BYTE_RESET;
            data_mid_ff <= ext_access_pkg::BYTE_RESET;
            data_high_ff <= ext_access_pkg::NIBBLE_RESET;
        end else if (state_ff == ST_RD_CAP) begin
            data_low_ff <= int_rdata[7:0];
            data_mid_ff <= int_rdata[15:8];
            data_high_ff <= int_rdata[19:16];
        end else if (acc_go && !acc_rd) begin
            if (acc_addr == ext_access_pkg::ADDR_DATA_MID) data_mid_ff <= acc_wdata;
            if (acc_addr == ext_access_pkg::ADDR_DATA_HIGH) begin
                data_high_ff <= acc_wdata[ext_access_pkg::HIGH_NIBBLE_HI:0];
            end
            if (dr0_wr) data_low_ff <= acc_wdata;
        end
    end

    // Write-only control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_down_ff <= ext_access_pkg::BYTE_RESET;
            soft_sync_ff <= ext_access_pkg::soft_sync_t'(ext_access_pkg::BYTE_RESET);
            pin_sync_ff <= ext_access_pkg::pin_sync_t'(ext_access_pkg::BYTE_RESET);
            soft_sync_stb_ff <= 1'b0;
        end else begin
            soft_sync_stb_ff <= 1'b0;
            if (acc_go && !acc_rd) begin
                if (acc_addr == ext_access_pkg::ADDR_POWER_DOWN) power_down_ff <= acc_wdata;
                if (acc_addr == ext_access_pkg::ADDR_SOFT_SYNC) begin
                    soft_sync_ff <= ext_access_pkg::soft_sync_t'(acc_wdata);
                    soft_sync_stb_ff <= 1'b1;
                end
                if (acc_addr == ext_access_pkg::ADDR_PIN_SYNC) begin
                    pin_sync_ff <= ext_access_pkg::pin_sync_t'(acc_wdata);
                end
            end
        end
    end

    // Internal access request toward the channels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_req_ff <= '0;
        end else begin
            int_req_ff.wr <= 1'b0;
            int_req_ff.rd <= 1'b0;
            if (dr0_wr || dr0_rd) begin
                // low byte write triggers; low byte read launches
                int_req_ff.wr <= dr0_wr;
                int_req_ff.rd <= dr0_rd;
                int_req_ff.io_sel <= power_down_ff[ext_access_pkg::SLEEP_IO_SEL];
                // mask from decoder, upper bits unused for multi-channel
                int_req_ff.chan_mask <= chan_mask;
                int_req_ff.addr <= {access_target_control_ff[ext_access_pkg::ACR_UPPER_HI:
                                    ext_access_pkg::ACR_UPPER_LO], channel_address_pointer_ff};
                int_req_ff.wdata <= {data_high_ff, data_mid_ff, acc_wdata};
            end
        end
    end

    // Answer routing to the requesting port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_rdata_ff <= ext_access_pkg::BYTE_RESET;
            up_rvalid_ff <= 1'b0;
            up_ready_ff <= 1'b1;
            ans_ser_ff <= 1'b0;
        end else begin
            up_rvalid_ff <= 1'b0;
            up_ready_ff <= !(dr0_rd || state_ff == ST_RD_WAIT);
            if (dr0_rd) ans_ser_ff <= acc_ser;
            if (ans_go && !(state_ff == ST_RD_CAP ? ans_ser_ff : acc_ser)) begin
                up_rdata_ff <= ans_data;
                up_rvalid_ff <= 1'b1;
            end
        end
    end

    // Serial frame shift logic
    assign sclk_rise = sclk && !sclk_ff;
    assign nxt_ser_in = {ser_in_ff[14:0], sdi};
    assign nxt_ser_cnt = ser_cnt_ff + 5'h01;

    // Serial port: command byte, then data byte in or out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_ff <= 1'b0;
            ser_cnt_ff <= 5'h00;
            ser_in_ff <= 16'h0000;
            ser_out_ff <= ext_access_pkg::BYTE_RESET;
            ser_pend_ff <= 1'b0;
            ser_pend_rd_ff <= 1'b0;
            ser_pend_addr_ff <= 3'h0;
            ser_pend_data_ff <= ext_access_pkg::BYTE_RESET;
        end else begin
            sclk_ff <= sclk;
            if (ser_take) ser_pend_ff <= 1'b0;
            if (ans_go && (state_ff == ST_RD_CAP ? ans_ser_ff : acc_ser)) begin
                ser_out_ff <= ans_data;
            end else if (sclk_rise && !sfs_n && ser_cnt_ff >= ext_access_pkg::SER_CMD_BITS) begin
                ser_out_ff <= {ser_out_ff[6:0], 1'b0};
            end
            if (sfs_n) begin
                ser_cnt_ff <= 5'h00;
            end else if (sclk_rise && ser_cnt_ff != ext_access_pkg::SER_FRAME_BITS) begin
                ser_in_ff <= nxt_ser_in;
                ser_cnt_ff <= nxt_ser_cnt;
                if (nxt_ser_cnt == ext_access_pkg::SER_CMD_BITS
                    && nxt_ser_in[ext_access_pkg::SER_CMD_READ]) begin
                    ser_pend_ff <= 1'b1;
                    ser_pend_rd_ff <= 1'b1;
                    ser_pend_addr_ff <= nxt_ser_in[2:0];
                end else if (nxt_ser_cnt == ext_access_pkg::SER_FRAME_BITS
                             && !nxt_ser_in[ext_access_pkg::SER_CMD_READ + 8]) begin
                    ser_pend_ff <= 1'b1;
                    ser_pend_rd_ff <= 1'b0;
                    ser_pend_addr_ff <= nxt_ser_in[10:8];
                    ser_pend_data_ff <= nxt_ser_in[7:0];
                end
            end
        end
    end

    assign up_rdata = up_rdata_ff;
    assign up_rvalid = up_rvalid_ff;
    assign up_ready = up_ready_ff;
    assign sdo = ser_out_ff[7];
    assign int_req = int_req_ff;
    assign soft_sync = soft_sync_ff;
    assign soft_sync_stb = soft_sync_stb_ff;
    assign pin_sync = pin_sync_ff;
    assign sleep = power_down_ff[ext_access_pkg::SLEEP_CHAN_HI:0];
endmodule
`default_nettype wire

// [ext_access_regs_asserts.sv]
// Concurrent checks on the ports of the external access register set
`default_nettype none
module ext_access_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] chip_identity_pins,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [2:0] up_addr,
    input wire logic [7:0] up_wdata,
    input wire logic [7:0] up_rdata,
    input wire logic up_rvalid,
    input wire logic up_ready,
    input wire ext_access_pkg::int_req_t int_req,
    input wire logic [19:0] int_rdata,
    input wire ext_access_pkg::soft_sync_t soft_sync,
    input wire logic soft_sync_stb,
    input wire ext_access_pkg::pin_sync_t pin_sync,
    input wire logic [3:0] sleep
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] acr_ff;
    logic tw;
    logic tr;
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted parallel writes and reads
    assign tw = up_wr && up_ready;
    assign tr = up_rd && !up_wr && up_ready;
    // Shadow of the access control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acr_ff <= 8'h00;
        end else if (tw && up_addr == 3'h7) begin
            acr_ff <= up_wdata;
        end
    end
    function automatic logic [3:0] exp_mask(input logic [7:0] a, input logic [3:0] id);
        logic [3:0] one;
        one = 4'h1 << a[1:0];
        if (!a[6]) begin
            return (a[5:2] == id) ? one : 4'h0;
        end
        case (a[5:2])
            4'h0: return 4'hf;
            4'h1: return 4'h7;
            4'h2: return 4'he;
            4'h4: return one;
            4'h8, 4'h9: return (a[2] == id[0]) ? one : 4'h0;
            4'hc, 4'hd, 4'he, 4'hf: return (a[3:2] == id[1:0]) ? one : 4'h0;
            default: return 4'h0;
        endcase
    endfunction
    chk_mask_decode: assert property (
        int_req.wr |-> int_req.chan_mask == exp_mask(acr_ff, chip_identity_pins)
        && int_req.chan_mask != 4'h0) else $error("channel mask wrong");
    chk_low_write_trig: assert property (
        int_req.wr |-> $past(tw && up_addr == 3'h0)) else $error("stray internal write");
    chk_low_read_seq: assert property (
        int_req.rd |-> !up_ready ##1 !up_ready ##1 (up_rvalid && up_ready
        && up_rdata == $past(int_rdata[7:0]))) else $error("low read sequence wrong");
    chk_soft_sync_load: assert property (
        tw && up_addr == 3'h5 |=> soft_sync_stb && soft_sync == $past(up_wdata))
        else $error("soft sync not loaded");
    chk_pin_sync_load: assert property (
        tw && up_addr == 3'h4 |=> pin_sync == $past(up_wdata)) else $error("pin sync");
    chk_sleep_load: assert property (
        tw && up_addr == 3'h3 |=> sleep == $past(up_wdata[3:0])) else $error("sleep bits");
    chk_wo_read_zero: assert property (
        tr && up_addr inside {3'h3, 3'h4, 3'h5} |=> up_rvalid && up_rdata == 8'h00)
        else $error("write-only read not zero");
    chk_high_nibble_read: assert property (
        tr && up_addr == 3'h2 |=> up_rvalid && up_rdata[7:4] == 4'h0)
        else $error("high data upper bits");
    chk_ptr_bcast_zero: assert property (
        tr && up_addr == 3'h6 && acr_ff[6] |=> up_rvalid && up_rdata == 8'h00)
        else $error("pointer read under broadcast");
endmodule
bind ext_access_regs ext_access_regs_chk chk_u (.clk(clk), .rst(rst),
    .chip_identity_pins(chip_identity_pins), .up_wr(up_wr), .up_rd(up_rd),
    .up_addr(up_addr), .up_wdata(up_wdata), .up_rdata(up_rdata), .up_rvalid(up_rvalid),
    .up_ready(up_ready), .int_req(int_req), .int_rdata(int_rdata), .soft_sync(soft_sync),
    .soft_sync_stb(soft_sync_stb), .pin_sync(pin_sync), .sleep(sleep));
`default_nettype wire

// [chan_mem_model.sv]
// Behavioural channel memory behind the internal request port
`default_nettype none
module chan_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire ext_access_pkg::int_req_t int_req,
    output logic [19:0] int_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] mem [0:1023];
    always_ff @(posedge clk) begin
        if (int_req.wr) begin
            mem[int_req.addr] <= int_req.wdata;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_rdata <= 20'h00000;
        end else if (int_req.rd) begin
            int_rdata <= mem[int_req.addr];
        end else begin
            int_rdata <= ~int_rdata;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the external access register set
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, up_wr, up_rd, up_rvalid, up_ready, sclk, sdi, sfs_n, sdo, soft_sync_stb;
    logic [2:0] up_addr;
    logic [7:0] up_wdata, up_rdata;
    logic [19:0] int_rdata;
    logic [3:0] sleep;
    logic [19:0] w [0:2];
    logic [15:0] ser_word [0:1] = '{16'h0309, 16'h8700};
    logic [7:0] ser_got;
    logic [3:0] chip_id = 4'h5;
    ext_access_pkg::int_req_t int_req;
    ext_access_pkg::soft_sync_t soft_sync;
    ext_access_pkg::pin_sync_t pin_sync;
    logic [33:0] wr_q[$];
    logic [7:0] rd_q[$];
    logic [31:0] seed = 32'h000148ec;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [3:0] codes [0:10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf, 4'h3};
    // Expected masks for identity 5, then for identity a
    logic [3:0] masks [0:21] = '{4'hf, 4'h7, 4'he, 4'h4, 4'h0, 4'h4, 4'h0, 4'h4, 4'h0, 4'h0,
        4'h0, 4'hf, 4'h7, 4'he, 4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0};
    ext_access_regs dut_u (.clk(clk), .rst(rst), .chip_identity_pins(chip_id), .up_wr(up_wr),
        .up_rd(up_rd), .up_addr(up_addr), .up_wdata(up_wdata), .up_rdata(up_rdata),
        .up_rvalid(up_rvalid), .up_ready(up_ready), .sclk(sclk), .sdi(sdi), .sfs_n(sfs_n),
        .sdo(sdo), .int_req(int_req), .int_rdata(int_rdata), .soft_sync(soft_sync),
        .soft_sync_stb(soft_sync_stb), .pin_sync(pin_sync), .sleep(sleep));
    chan_mem_model mem_u (.clk(clk), .rst(rst), .int_req(int_req), .int_rdata(int_rdata));
    // Clock generation
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Wait at a falling edge until the port is idle
    task automatic go();
        int n;
        @(negedge clk);
        for (n = 0; n < 10 && up_ready !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        go();
        up_addr = a;
        up_wdata = d;
        up_wr = 1'b1;
        @(negedge clk);
        up_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        go();
        up_addr = a;
        up_rd = 1'b1;
        rd_q.push_back(e);
        @(negedge clk);
        up_rd = 1'b0;
    endtask
    // Load a 20-bit word: high and middle first, low last
    task automatic put(input logic [19:0] v, input logic [3:0] m, input logic [9:0] ad);
        wr(3'h2, {4'ha, v[19:16]});
        wr(3'h1, v[15:8]);
        if (m != 4'h0) wr_q.push_back({m, ad, v});
        wr(3'h0, v[7:0]);
    endtask
    // Monitor takes the oldest note whenever a result appears
    always @(negedge clk) begin
        if (rst === 1'b0 && up_rvalid === 1'b1) begin
            check(up_rdata, rd_q.size() ? rd_q.pop_front() : 8'hxx); // readback
        end
        if (rst === 1'b0 && int_req.wr === 1'b1) begin
            check({int_req.io_sel, int_req.chan_mask, int_req.addr, int_req.wdata},
                {1'b0, wr_q.size() ? wr_q.pop_front() : 34'hx}); // write
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {rst, up_wr, up_rd, sclk, sdi, sfs_n} = 6'b100001;
        up_addr = 3'h0;
        up_wdata = 8'h00;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        rd(3'h7, 8'h00); // control reset
        rd(3'h6, 8'h00); // pointer reset
        $display("reset test done");
        for (int i = 0; i < 22; i++) begin
            wr(3'h7, {2'b01, codes[i % 11], 2'b10});
            chip_id = (i < 11) ? 4'h5 : 4'ha;
            wr(3'h6, 8'h20 + 8'(i));
            put(20'(xs()), masks[i], {2'b10, 8'h20 + 8'(i)});
        end
        chip_id = 4'h5;
        $display("broadcast test done");
        wr(3'h7, 8'h95);
        wr(3'h6, 8'h40);
        for (int k = 0; k < 3; k++) begin
            w[k] = 20'(xs());
            put(w[k], 4'h2, {2'b01, 8'h40 + 8'(k)}); // auto step
        end
        wr(3'h7, 8'h99);
        put(20'(xs()), 4'h0, 10'h000); // foreign chip ignored
        rd(3'h6, 8'h43); // pointer
        wr(3'h7, 8'h15);
        wr(3'h6, 8'h40);
        rd(3'h0, w[0][7:0]); // low first
        rd(3'h1, w[0][15:8]); // middle
        rd(3'h2, {4'h0, w[0][19:16]}); // high nibble
        rd(3'h6, 8'h40); // no step
        wr(3'h7, 8'h95);
        wr(3'h6, 8'h41);
        rd(3'h0, w[1][7:0]); // read step
        rd(3'h6, 8'h42); // stepped
        wr(3'h7, 8'h40);
        rd(3'h6, 8'h00); // hidden pointer
        wr(3'h7, 8'h15);
        $display("channel test done");
        wr(3'h5, 8'hb6);
        check(soft_sync_stb, 1'b1); // strobe
        check(soft_sync, 8'hb6); // fields
        wr(3'h4, 8'h6c);
        check(soft_sync_stb, 1'b0); // one pulse
        check(pin_sync, 8'h6c); // fields
        wr(3'h3, 8'hfa);
        check(sleep, 4'ha); // sleep bits
        for (int r = 3; r < 6; r++) rd(3'(r), 8'h00); // write-only
        $display("sync test done");
        // Serial write of the sleep bits, then a serial read of access control
        for (int f = 0; f < 2; f++) begin
            sfs_n = 1'b0;
            for (int b = 15; b >= 0; b--) begin
                sdi = ser_word[f][b];
                repeat (3) @(negedge clk);
                ser_got = {ser_got[6:0], sdo};
                sclk = 1'b1;
                repeat (3) @(negedge clk);
                sclk = 1'b0;
            end
            sfs_n = 1'b1;
            repeat (6) @(negedge clk);
        end
        check(sleep, 4'h9); // serial write
        check(ser_got, 8'h15); // serial readback
        $display("serial test done");
        repeat (6) @(negedge clk);
        check(64'(wr_q.size() + rd_q.size()), 64'h0); // all seen
        close_out();
    end
endmodule
`default_nettype wire
